// ---- smtc_defines.vh ----
`ifndef SMTC_DEFINES_VH
`define SMTC_DEFINES_VH
// Field positions of the secure monitor configuration word
`define SMTC_BIT_SEC 0
`define SMTC_BIT_SMD 7
`define SMTC_BIT_HCE 8
`define SMTC_BIT_SIF 9
`define SMTC_BIT_RW 10
`define SMTC_BIT_ST 11
`define SMTC_BIT_TWI 12
`define SMTC_BIT_LEVEL2_SECURE_ENABLE 18
`define SMTC_BIT_NSE 62
`define SMTC_RES1_MASK 64'h0000_0000_0000_0030
// Syndrome classes
`define SMTC_EC_UNDEF 6'h00
`define SMTC_EC_WAIT 6'h01
`define SMTC_EC_SYSREG 6'h18
// Exception levels
`define SMTC_EL0 2'h0
`define SMTC_EL1 2'h1
`define SMTC_EL2 2'h2
`define SMTC_EL3 2'h3
// Security states from extension and security bits
`define SMTC_SS_SECURE 2'h0
`define SMTC_SS_NONSEC 2'h1
`define SMTC_SS_RSVD 2'h2
`define SMTC_SS_REALM 2'h3
`endif

// ---- smtc_wait_trap.v ----
`timescale 1ns/1ps
`include "smtc_defines.vh"
module smtc_wait_trap #(
  parameter TIMED_WAIT_EXT = 1
) (
  input wire wait_irq_trap,
  input wire [1:0] cur_el,
  input wire wfi_valid,
  input wire timed_valid,
  input wire is32,
  input wire cond_pass,
  input wire would_sleep,
  input wire lower_trap,
  output wire take
);
  wire insn;
  // Timed form shares the trap only when the extension exists
  assign insn = wfi_valid | (timed_valid & (TIMED_WAIT_EXT != 0)); // RULE2
  // Early completion clears would_sleep, so no trap is owed then
  assign take = wait_irq_trap & insn & (cur_el != `SMTC_EL3) &
    would_sleep & ~lower_trap & // RULE1 RULE4
    (~is32 | cond_pass); // RULE3
endmodule // smtc_wait_trap

// ---- smtc_call_check.v ----
`timescale 1ns/1ps
`include "smtc_defines.vh"
module smtc_call_check (
  input wire hypervisor_call,
  input wire monitor_call,
  input wire [1:0] cur_el,
  input wire el2_enabled,
  input wire sec_el1_no_el2,
  input wire hyp_call_enable,
  input wire monitor_call_disable,
  input wire hyp_monitor_call_trap,
  output wire hvc_undef,
  output wire smc_undef,
  output wire smc_to_el2
);
  wire hvc_ok;
  assign hvc_ok = hyp_call_enable & (cur_el != `SMTC_EL0) & ~sec_el1_no_el2 &
    ((cur_el == `SMTC_EL3) | el2_enabled); // RULE13 RULE14
  assign hvc_undef = hypervisor_call & ~hvc_ok; // RULE13 RULE14
  // Hypervisor trap outranks the disable at level 1
  assign smc_to_el2 = monitor_call & (cur_el == `SMTC_EL1) &
    hyp_monitor_call_trap; // RULE18
  assign smc_undef = monitor_call & ~smc_to_el2 &
    ((cur_el == `SMTC_EL0) | monitor_call_disable); // RULE16 RULE17
endmodule // smtc_call_check

// ---- smtc_trap_ctrl.v ----
`timescale 1ns/1ps
`include "smtc_defines.vh"
// Operation
// RULE1 - wait trap sends lower-level wait up
// RULE2 - timed wait trapped the same way
// RULE3 - 32-bit conditional wait trapped only passing
// RULE4 - trap owed only when wait would sleep
// RULE5 - secure timer access trapped at secure level-1
// RULE6 - timer always level-3, never level-0
// RULE7 - width field picks lower-level execution state
// RULE8 - width forced to one for non-secure case
// RULE9 - width forced to one for secure level-2
// RULE10 - width field fixed one without 32-bit
// RULE11 - fetch block on stage-1 non-secure memory
// RULE12 - fetch block on non-secure memory
// RULE13 - hypervisor call enable gates hypervisor calls
// RULE14 - hypervisor call undefined at level-0, secure level-1
// RULE15 - hypervisor enable reads zero without level-2
// RULE16 - monitor disable makes monitor calls undefined
// RULE17 - monitor calls undefined at level 0
// RULE18 - hypervisor monitor trap beats disable field
// RULE19 - two bits select lower security state
// RULE20 - bit six zero, bits five four one
// RULE21 - software flushes translations after field change
module smtc_trap_ctrl #(
  parameter HAS_EL2 = 1,
  parameter SEL2 = 1,
  parameter EL1_A32 = 1,
  parameter EL2_A32 = 1,
  parameter TIMED_WAIT_EXT = 1
) (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] cur_el,
  input wire cfg_wr,
  input wire [63:0] cfg_wdata,
  input wire wfi_valid,
  input wire timed_valid,
  input wire is32,
  input wire cond_pass,
  input wire would_sleep,
  input wire lower_wait_trap,
  input wire timer_acc,
  input wire is64,
  input wire hypervisor_call,
  input wire monitor_call,
  input wire hyp_monitor_call_trap,
  input wire fetch_ns,
  input wire fetch_valid,
  output reg [63:0] cfg_rdata,
  output reg trap_valid,
  output reg [5:0] trap_class,
  output reg [1:0] trap_target,
  output reg undef_valid,
  output reg fetch_fault,
  output reg timer_undef,
  output reg lower_is64,
  output reg [1:0] sec_state
);
  // ==========================================================
  // Configuration storage
  // ==========================================================
  reg twi_r;
  reg st_r;
  reg rw_r;
  reg sif_r;
  reg hce_r;
  reg smd_r;
  reg ns_r;
  reg nse_r;
  reg level2_secure_enable_r;
  wire rw_wr_ok = (EL1_A32 != 0) | (EL2_A32 != 0);
  wire cfg_take;
  // Only the top level may write; lower levels are refused
  assign cfg_take = cfg_wr & (cur_el == `SMTC_EL3);
  // Fields have no defined warm-reset value; zero chosen for safety, except the width field, which resets to one

  // Wait trap
  always @(posedge clk_sys) begin
    if (rst) begin
      twi_r <= 1'b0;
    end else if (cfg_take) begin
      twi_r <= cfg_wdata[`SMTC_BIT_TWI]; // RULE1
    end
  end

  // Secure timer trap
  always @(posedge clk_sys) begin
    if (rst) begin
      st_r <= 1'b0;
    end else if (cfg_take) begin
      st_r <= cfg_wdata[`SMTC_BIT_ST]; // RULE5
    end
  end

  // Width field: stuck at one when no 32-bit level exists
  always @(posedge clk_sys) begin
    if (rst) begin
      rw_r <= 1'b1;
    end else if (cfg_take && rw_wr_ok) begin
      rw_r <= cfg_wdata[`SMTC_BIT_RW]; // RULE10
    end
  end

  // Secure fetch block
  always @(posedge clk_sys) begin
    if (rst) begin
      sif_r <= 1'b0;
    end else if (cfg_take) begin
      sif_r <= cfg_wdata[`SMTC_BIT_SIF]; // RULE11 RULE12
    end
  end

  // Hypervisor call enable, reserved without level 2
  always @(posedge clk_sys) begin
    if (rst) begin
      hce_r <= 1'b0;
    end else if (cfg_take) begin
      hce_r <= cfg_wdata[`SMTC_BIT_HCE] & (HAS_EL2 != 0); // RULE15
    end
  end

  // Monitor call disable
  always @(posedge clk_sys) begin
    if (rst) begin
      smd_r <= 1'b0;
    end else if (cfg_take) begin
      smd_r <= cfg_wdata[`SMTC_BIT_SMD]; // RULE16
    end
  end

  // Security bit
  always @(posedge clk_sys) begin
    if (rst) begin
      ns_r <= 1'b0;
    end else if (cfg_take) begin
      ns_r <= cfg_wdata[`SMTC_BIT_SEC]; // RULE19
    end
  end

  // Security extension bit
  always @(posedge clk_sys) begin
    if (rst) begin
      nse_r <= 1'b0;
    end else if (cfg_take) begin
      nse_r <= cfg_wdata[`SMTC_BIT_NSE]; // RULE19
    end
  end

  // Secure level-2 enable, dead when that level is absent
  always @(posedge clk_sys) begin
    if (rst) begin
      level2_secure_enable_r <= 1'b0;
    end else if (cfg_take) begin
      level2_secure_enable_r <= cfg_wdata[`SMTC_BIT_LEVEL2_SECURE_ENABLE] & (SEL2 != 0);
    end
  end

  // ==========================================================
  // Effective values
  // ==========================================================
  wire rw_eff;
  wire sec_el2_en;
  wire el2_enabled;
  wire secure;
  assign secure = ~nse_r & ~ns_r; // RULE19
  assign sec_el2_en = (SEL2 != 0) & level2_secure_enable_r;
  assign el2_enabled = (HAS_EL2 != 0) & (~secure | sec_el2_en);
  wire rw_fixed;
  wire rw_force_ns;
  wire rw_force_sel2;
  // Non-secure and secure level-2 forcing only affect behaviour; reads keep the stored bit, but the fixed case reads as one
  assign rw_fixed = ~rw_wr_ok; // RULE10
  assign rw_force_ns = (EL1_A32 != 0) & ns_r & (EL2_A32 == 0); // RULE8
  assign rw_force_sel2 = (EL1_A32 != 0) & sec_el2_en & ~ns_r; // RULE9
  assign rw_eff = rw_fixed | rw_r | rw_force_ns | rw_force_sel2; // RULE7

  // ==========================================================
  // Trap decisions
  // ==========================================================
  wire wait_take;
  wire hvc_undef;
  wire smc_undef;
  wire smc_to_el2;
  wire sec_el1_no_el2;
  // Secure level 1 without secure level 2 never gets hypervisor calls
  assign sec_el1_no_el2 = secure & ~sec_el2_en & (cur_el == `SMTC_EL1);
  smtc_wait_trap #(.TIMED_WAIT_EXT(TIMED_WAIT_EXT)) u_wait (
    .wait_irq_trap(twi_r),
    .cur_el(cur_el),
    .wfi_valid(wfi_valid),
    .timed_valid(timed_valid),
    .is32(is32),
    .cond_pass(cond_pass),
    .would_sleep(would_sleep),
    .lower_trap(lower_wait_trap),
    .take(wait_take)
  );
  smtc_call_check u_call (
    .hypervisor_call(hypervisor_call),
    .monitor_call(monitor_call),
    .cur_el(cur_el),
    .el2_enabled(el2_enabled),
    .sec_el1_no_el2(sec_el1_no_el2), // RULE14
    .hyp_call_enable(hce_r),
    .monitor_call_disable(smd_r),
    .hyp_monitor_call_trap(hyp_monitor_call_trap),
    .hvc_undef(hvc_undef),
    .smc_undef(smc_undef),
    .smc_to_el2(smc_to_el2)
  );
  wire timer_take;
  wire timer_el0;
  wire undef_any;
  wire fetch_block;
  // Secure level-2 enabled makes the field act as one
  assign timer_take = timer_acc & is64 & secure & ~sec_el2_en &
    (cur_el == `SMTC_EL1) & ~st_r; // RULE5
  assign timer_el0 = timer_acc & (cur_el == `SMTC_EL0); // RULE6
  assign undef_any = hvc_undef | smc_undef;
  // Stage-1 marking or plain non-secure: same input either way
  assign fetch_block = fetch_valid & secure & sif_r &
    fetch_ns; // RULE11 RULE12

  reg [63:0] rd_nxt;
  always @* begin
    rd_nxt = `SMTC_RES1_MASK; // RULE20
    rd_nxt[`SMTC_BIT_TWI] = twi_r;
    rd_nxt[`SMTC_BIT_ST] = st_r;
    rd_nxt[`SMTC_BIT_RW] = rw_r | ~rw_wr_ok; // RULE10
    rd_nxt[`SMTC_BIT_SIF] = sif_r;
    rd_nxt[`SMTC_BIT_HCE] = hce_r; // RULE15
    rd_nxt[`SMTC_BIT_SMD] = smd_r;
    rd_nxt[`SMTC_BIT_SEC] = ns_r;
    rd_nxt[`SMTC_BIT_NSE] = nse_r;
    rd_nxt[`SMTC_BIT_LEVEL2_SECURE_ENABLE] = level2_secure_enable_r;
  end

  // ==========================================================
  // Trap priority
  // ==========================================================
  // Undefined outranks the level-2 trap, then timer, then wait
  reg [5:0] class_nxt;
  reg [1:0] target_nxt;
  always @* begin
    class_nxt = `SMTC_EC_WAIT; // RULE1
    target_nxt = `SMTC_EL3;
    if (undef_any) begin
      class_nxt = `SMTC_EC_UNDEF;
      target_nxt = cur_el; // RULE14 RULE17
    end else if (smc_to_el2) begin
      class_nxt = `SMTC_EC_UNDEF;
      target_nxt = `SMTC_EL2; // RULE18
    end else if (timer_take) begin
      class_nxt = `SMTC_EC_SYSREG; // RULE5
      target_nxt = `SMTC_EL3;
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  // Read image and level outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      cfg_rdata <= 64'h0;
      lower_is64 <= 1'b0;
      sec_state <= `SMTC_SS_SECURE;
    end else begin
      cfg_rdata <= rd_nxt;
      lower_is64 <= rw_eff; // RULE7
      sec_state <= {nse_r, ns_r}; // RULE19
    end
  end

  // One-cycle event outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      trap_valid <= 1'b0;
      undef_valid <= 1'b0;
      fetch_fault <= 1'b0;
      timer_undef <= 1'b0;
    end else begin
      trap_valid <= wait_take | timer_take | undef_any | smc_to_el2;
      undef_valid <= undef_any; // RULE14 RULE17
      fetch_fault <= fetch_block; // RULE11 RULE12
      timer_undef <= timer_el0; // RULE6
    end
  end

  // Syndrome fields, only meaningful beside trap_valid
  always @(posedge clk_sys) begin
    if (rst) begin
      trap_class <= `SMTC_EC_UNDEF;
      trap_target <= `SMTC_EL0;
    end else begin
      trap_class <= class_nxt;
      trap_target <= target_nxt;
    end
  end
endmodule // smtc_trap_ctrl

// ---- smtc_checker.sv ----
`timescale 1ns/1ps
// ====================
// Port checker
module smtc_checker (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] cur_el,
  input wire cfg_wr,
  input wire wfi_valid,
  input wire is32,
  input wire would_sleep,
  input wire lower_wait_trap,
  input wire timer_acc,
  input wire hypervisor_call,
  input wire monitor_call,
  input wire hyp_monitor_call_trap,
  input wire fetch_ns,
  input wire fetch_valid,
  input wire [63:0] cfg_rdata,
  input wire trap_valid,
  input wire [5:0] trap_class,
  input wire [1:0] trap_target,
  input wire undef_valid,
  input wire fetch_fault,
  input wire timer_undef
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Read image lags a write, so fresh writes are excluded
  wire quiet = !hypervisor_call && !monitor_call && !timer_acc;
  a_wait_trap_up: assert property (
    wfi_valid && cur_el != 2'h3 && would_sleep
    && !lower_wait_trap && !is32 && quiet && cfg_rdata[12] && !$past(cfg_wr)
    |=> trap_valid && trap_class == 6'h01 && trap_target == 2'h3)
    else $error("wait not trapped");
  a_smc_el0_undef: assert property (monitor_call && cur_el == 2'h0 |=> undef_valid)
    else $error("monitor call at level 0 not undefined");
  a_hvc_el0_undef: assert property (hypervisor_call && cur_el == 2'h0 |=> undef_valid)
    else $error("hypervisor call at level 0 not undefined");
  a_smd_undef: assert property (monitor_call && cur_el != 2'h0 && cfg_rdata[7]
    && !(hyp_monitor_call_trap && cur_el == 2'h1) && !$past(cfg_wr)
    |=> undef_valid) else $error("disabled monitor call not undefined");
  a_timer_el0_undef: assert property (timer_acc && cur_el == 2'h0
    |=> timer_undef) else $error("timer access at level 0 allowed");
  a_reserved_bits: assert property (!$past(rst) && !$past(rst, 2)
    |-> cfg_rdata[6:4] == 3'h3) else $error("reserved bits wrong");
  a_write_refused: assert property (cfg_wr && cur_el != 2'h3 && !$past(cfg_wr)
    && !$past(rst) |=> ##1 $stable(cfg_rdata))
    else $error("write below top level took effect");
  a_fetch_blocked: assert property (
    fetch_valid && fetch_ns && cfg_rdata[9]
    && !cfg_rdata[62] && !cfg_rdata[0] && !$past(cfg_wr)
    |=> fetch_fault) else $error("secure fetch from non-secure allowed");
  c_timer_trap: cover property (trap_valid && trap_class == 6'h18);
  c_fetch: cover property (fetch_fault);
  c_undef: cover property (undef_valid);
endmodule // smtc_checker

bind smtc_trap_ctrl smtc_checker u_chk (.*);

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0, rst = 1'b1, cfg_wr = 1'b0, is64 = 1'b1;
  reg [1:0] cur_el = 2'h3;
  reg [63:0] cfg_wdata = 64'h0;
  reg wfi_valid = 1'b0, timed_valid = 1'b0, is32 = 1'b0, cond_pass = 1'b0;
  reg would_sleep = 1'b0, lower_wait_trap = 1'b0, timer_acc = 1'b0;
  reg hypervisor_call = 1'b0, monitor_call = 1'b0, hyp_monitor_call_trap = 1'b0;
  reg fetch_ns = 1'b0, fetch_valid = 1'b0;
  wire [63:0] cfg_rdata;
  wire [5:0] trap_class;
  wire [1:0] trap_target, sec_state;
  wire trap_valid, undef_valid, fetch_fault, timer_undef, lower_is64;
  integer failures = 0, check_count = 0;
  smtc_trap_ctrl uut (.*);
  always #2.5 clk_sys = ~clk_sys;
  // ====================
  // Shared tasks
  task chk(input [63:0] got, input [63:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk_sys);
    #1;
    {wfi_valid, timed_valid, cfg_wr, timer_acc, hypervisor_call, monitor_call, fetch_valid} = 7'h00;
  endtask
  task wcfg(input [63:0] v);
    step; cur_el = 2'h3; cfg_wdata = v; cfg_wr = 1'b1; step; step;
  endtask
  task wt(input [1:0] el, input tv, a32, cp, lw, ex);
    step; cur_el = el; wfi_valid = !tv; timed_valid = tv; is32 = a32;
    cond_pass = cp; lower_wait_trap = lw; would_sleep = 1'b1; step;
    chk(trap_valid, ex);
    if (ex) chk({trap_class, trap_target}, {6'h01, 2'h3});
  endtask
  task call(input [1:0] el, input h, s, ht, ex);
    step; cur_el = el; hypervisor_call = h; monitor_call = s; hyp_monitor_call_trap = ht; step;
    chk(undef_valid, ex);
  endtask
  task tm(input [1:0] el, input et, eu);
    step; cur_el = el; timer_acc = 1'b1; step;
    chk({trap_valid, timer_undef}, {et, eu});
    if (et) chk({trap_class, trap_target}, {6'h18, 2'h3});
  endtask
  task ft(input ns, ex);
    step; fetch_valid = 1'b1; fetch_ns = ns; step;
    chk(fetch_fault, ex);
  endtask
  // ====================
  // Scenarios
  task t_regs;
    chk(cfg_rdata, 64'h0000_0000_0000_0430);
    wcfg(64'hFFFF_FFFF_FFFF_FFFF);
    chk(cfg_rdata[12:4], 64'h1FB);
    wcfg(64'h0);
    chk(cfg_rdata[12:4], 64'h003);
    step; cur_el = 2'h2; cfg_wdata = 64'h1F80; cfg_wr = 1'b1; step; step;
    chk(cfg_rdata[12:4], 64'h003);
  endtask
  task t_wait;
    wcfg(64'h1001);
    wt(2'h0, 0, 0, 0, 0, 1); wt(2'h1, 0, 0, 0, 0, 1); wt(2'h2, 0, 0, 0, 0, 1);
    wt(2'h1, 1, 0, 0, 0, 1);
    wt(2'h1, 0, 1, 0, 0, 0); wt(2'h1, 0, 1, 1, 0, 1);
    wt(2'h1, 0, 0, 0, 1, 0); wt(2'h3, 0, 0, 0, 0, 0);
    step; cur_el = 2'h1; wfi_valid = 1'b1; lower_wait_trap = 1'b0;
    is32 = 1'b0; would_sleep = 1'b0; step;
    chk(trap_valid, 1'b0);
    wcfg(64'h1); wt(2'h1, 0, 0, 0, 0, 0);
  endtask
  task t_calls;
    wcfg(64'h101); call(2'h1, 1, 0, 0, 0); call(2'h0, 1, 0, 0, 1);
    call(2'h0, 0, 1, 0, 1); call(2'h1, 0, 1, 0, 0);
    wcfg(64'h81); call(2'h2, 1, 0, 0, 1); call(2'h2, 0, 1, 0, 1);
    call(2'h1, 0, 1, 1, 0);
    chk({trap_valid, trap_class, trap_target}, {1'b1, 6'h00, 2'h2});
    wcfg(64'h100); call(2'h1, 1, 0, 0, 1);
  endtask
  task t_timer;
    wcfg(64'h0); tm(2'h1, 1, 0); tm(2'h0, 0, 1); tm(2'h3, 0, 0);
    wcfg(64'h40000); tm(2'h1, 0, 0);
  endtask
  task t_state;
    wcfg(64'h200); ft(1, 1); ft(0, 0);
    chk(sec_state, 2'h0);
    wcfg(64'h201); ft(1, 0);
    chk(lower_is64, 1'b0);
    wcfg(64'h400); chk(lower_is64, 1'b1);
    wcfg(64'h40000); chk(lower_is64, 1'b1);
    wcfg(64'h4000_0000_0000_0001); chk(sec_state, 2'h3);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    step; step;
    t_regs; t_wait; t_calls; t_timer; t_state;
    give_verdict;
  end
  initial begin
    #20000 failures = failures + 1;
    give_verdict;
  end
endmodule // testbench
